//--- logic/adcsel_top.sv
// Purpose: converter positive-input select register and sensor offset storage
// Assumes: paged register access on sys_clk; factory offset arrives on pins
// Notes: read data appears one cycle after the read strobe
//
// Behaviour
// R1 - channel field 4:0 selects port pins
// R2 - codes 11011-11111 select sensor, supplies, ground
// R3 - software passes through ground before sensor
// R4 - ground selection discharges the sampling capacitor
// R5 - sensor output routed as positive input
// R6 - disabled sensor is high impedance, data meaningless
// R7 - high offset byte holds offset bits 9:2
// R8 - offset is production value, software cannot write
// R9 - software performs its own offset calibration
// R10 - low offset byte: bits 7:6, rest zero
// R11 - select bits 7:5 zero, reset selects ground
// R12 - reserved codes stored, input undefined
`timescale 1ns/1ps
`include "adcsel_defs.svh"

module adcsel_top (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [3:0] sfr_page,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic sfr_rvalid,
  input wire logic [9:0] temp_offset_value,
  input wire logic temp_sensor_enable,
  output logic [4:0] input_channel_field,
  output adcsel_pkg::adcsel_src_e analog_input_mux,
  output logic [2:0] mux_pin,
  output logic [7:0] mux_pin_onehot,
  output logic cap_discharge,
  output logic sensor_drive_en,
  output logic sensor_route,
  output logic sensor_result_valid,
  output logic sel_reserved,
  output logic skip_ground_seen,
  output logic offset_loaded
);

  localparam logic [2:0] SETTLE_CYC = 3'(`ADCSEL_TRIM_SETTLE_CYC);

  localparam adcsel_pkg::adcsel_state_s ST_RESET = '{
    chan: `ADCSEL_CHAN_RESET,
    rdata: `ADCSEL_RDATA_RESET,
    rvalid: 1'b0,
    offs: 10'h000,
    trim_s1: 10'h000,
    trim_s2: 10'h000,
    trim_state: adcsel_pkg::TRIM_SYNC,
    settle_cnt: 3'h0,
    loaded: 1'b0,
    src: adcsel_pkg::SRC_GND,
    pin: 3'h0,
    pin_onehot: 8'h00,
    cap_discharge: 1'b1,
    sensor_drive_en: 1'b0,
    sensor_route: 1'b0,
    sensor_valid: 1'b0,
    sel_reserved: 1'b0,
    skip_ground_seen: 1'b0
  };

  adcsel_pkg::adcsel_state_s st_reg;
  adcsel_pkg::adcsel_state_s st_next;

  logic hit_chan;
  logic hit_offs_high;
  logic hit_offs_low;
  logic chan_write;
  logic [4:0] chan_next;
  adcsel_pkg::adcsel_src_e dec_src;
  logic [2:0] dec_pin;
  logic [7:0] dec_onehot;

  // address decode: the page must match as well as the address
  assign hit_chan = (sfr_page == `ADCSEL_PAGE_MAIN) && (sfr_addr == `ADCSEL_ADDR_CHAN);
  assign hit_offs_high = (sfr_page == `ADCSEL_PAGE_CFG) && (sfr_addr == `ADCSEL_ADDR_OFFS_HIGH);
  assign hit_offs_low = (sfr_page == `ADCSEL_PAGE_CFG) && (sfr_addr == `ADCSEL_ADDR_OFFS_LOW);
  assign chan_write = sfr_wr && hit_chan;

  // bits 7:5 of a write are dropped; any 5-bit code is stored as written
  assign chan_next = chan_write ? sfr_wdata[`ADCSEL_CHAN_MSB:0] : st_reg.chan; // R1 R11 R12

  adcsel_decode u_decode (
    .code(chan_next),
    .src(dec_src),
    .pin(dec_pin),
    .pin_onehot(dec_onehot)
  );

  always_comb begin
    st_next = st_reg;

    // channel select register and its decoded mux controls
    st_next.chan = chan_next; // R1
    st_next.src = dec_src; // R1 R2
    st_next.pin = dec_pin; // R1
    st_next.pin_onehot = dec_onehot; // R1
    st_next.sel_reserved = (dec_src == adcsel_pkg::SRC_RSVD); // R12
    st_next.cap_discharge = (dec_src == adcsel_pkg::SRC_GND); // R4
    st_next.sensor_route = (dec_src == adcsel_pkg::SRC_TEMP); // R5

    // sensor output stays high impedance while disabled
    st_next.sensor_drive_en = temp_sensor_enable; // R6
    st_next.sensor_valid = temp_sensor_enable && (dec_src == adcsel_pkg::SRC_TEMP); // R5 R6

    // flags a jump onto the sensor that skipped the ground step; set wins
    if (chan_write && chan_next == `ADCSEL_CODE_GND) begin
      st_next.skip_ground_seen = 1'b0;
    end
    if (chan_write && chan_next == `ADCSEL_CODE_TEMP &&
        st_reg.chan != `ADCSEL_CODE_GND && st_reg.chan != `ADCSEL_CODE_TEMP) begin
      st_next.skip_ground_seen = 1'b1; // R3
    end

    // factory offset pins: two-stage synchroniser, then captured once
    st_next.trim_s1 = temp_offset_value;
    st_next.trim_s2 = st_reg.trim_s1;
    case (st_reg.trim_state)
      adcsel_pkg::TRIM_SYNC: begin
        st_next.settle_cnt = 3'h0;
        st_next.trim_state = adcsel_pkg::TRIM_SETTLE;
      end
      adcsel_pkg::TRIM_SETTLE: begin
        if (st_reg.settle_cnt >= SETTLE_CYC - 3'h1) begin
          st_next.offs = st_reg.trim_s2; // R8
          st_next.loaded = 1'b1; // R8
          st_next.trim_state = adcsel_pkg::TRIM_HOLD;
        end else begin
          st_next.settle_cnt = st_reg.settle_cnt + 3'h1;
        end
      end
      adcsel_pkg::TRIM_HOLD: begin
        st_next.offs = st_reg.offs; // R8
      end
      default: begin
        st_next.trim_state = adcsel_pkg::TRIM_SYNC;
      end
    endcase

    // register reads, answered one cycle later; unmapped reads return zero
    st_next.rvalid = sfr_rd;
    st_next.rdata = `ADCSEL_RDATA_RESET;
    if (sfr_rd) begin
      if (hit_chan) begin
        st_next.rdata = {3'h0, st_reg.chan}; // R11
      end else if (hit_offs_high) begin
        st_next.rdata = st_reg.offs[9:2]; // R7
      end else if (hit_offs_low) begin
        st_next.rdata = {st_reg.offs[1:0], 6'h00}; // R10
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= ST_RESET; // R11
    end else begin
      st_reg <= st_next;
    end
  end

  assign sfr_rdata = st_reg.rdata;
  assign sfr_rvalid = st_reg.rvalid;
  assign input_channel_field = st_reg.chan;
  assign analog_input_mux = st_reg.src;
  assign mux_pin = st_reg.pin;
  assign mux_pin_onehot = st_reg.pin_onehot;
  assign cap_discharge = st_reg.cap_discharge;
  assign sensor_drive_en = st_reg.sensor_drive_en;
  assign sensor_route = st_reg.sensor_route;
  assign sensor_result_valid = st_reg.sensor_valid;
  assign sel_reserved = st_reg.sel_reserved;
  assign skip_ground_seen = st_reg.skip_ground_seen;
  assign offset_loaded = st_reg.loaded;

endmodule

//--- logic/adcsel_defs.svh
// Purpose: constants for the converter input select and sensor offset block
// Assumes: 8-bit paged special-function-register access, 100 MHz core clock
// Notes: page/address pairs, field positions, reset values and timing counts
`ifndef ADCSEL_DEFS_SVH
`define ADCSEL_DEFS_SVH

// register pages and addresses
`define ADCSEL_PAGE_MAIN 4'h0
`define ADCSEL_PAGE_CFG 4'hF
`define ADCSEL_ADDR_CHAN 8'hBB
`define ADCSEL_ADDR_OFFS_HIGH 8'h86
`define ADCSEL_ADDR_OFFS_LOW 8'h85

// field positions
`define ADCSEL_CHAN_MSB 4
`define ADCSEL_OFFS_LOW_LSB 6

// reset values
`define ADCSEL_CHAN_RESET 5'h1F
`define ADCSEL_RDATA_RESET 8'h00

// channel codes
`define ADCSEL_CODE_P0_LAST 5'h07
`define ADCSEL_CODE_P1_FIRST 5'h0D
`define ADCSEL_CODE_P1_LAST 5'h0F
`define ADCSEL_CODE_P2_FIRST 5'h10
`define ADCSEL_CODE_P2_LAST 5'h16
`define ADCSEL_CODE_TEMP 5'h1B
`define ADCSEL_CODE_VDD 5'h1C
`define ADCSEL_CODE_VREG 5'h1D
`define ADCSEL_CODE_VDD_ALT 5'h1E
`define ADCSEL_CODE_GND 5'h1F

// timing: factory trim settle time after reset release
`define ADCSEL_CLK_PERIOD_NS 10
`define ADCSEL_TRIM_SETTLE_NS 40
`define ADCSEL_TRIM_SETTLE_CYC \
  ((`ADCSEL_TRIM_SETTLE_NS + `ADCSEL_CLK_PERIOD_NS - 1) / `ADCSEL_CLK_PERIOD_NS)

`endif

//--- logic/adcsel_pkg.sv
// Purpose: types shared by the input select block
// Assumes: constants live in adcsel_defs.svh
// Notes: state of the top module is one packed struct
package adcsel_pkg;

  typedef enum logic [2:0] {
    SRC_PORT0,
    SRC_PORT1,
    SRC_PORT2,
    SRC_TEMP,
    SRC_VDD,
    SRC_VREG,
    SRC_GND,
    SRC_RSVD
  } adcsel_src_e;

  typedef enum logic [1:0] {
    TRIM_SYNC,
    TRIM_SETTLE,
    TRIM_HOLD
  } adcsel_trim_e;

  typedef struct packed {
    logic [4:0] chan;
    logic [7:0] rdata;
    logic rvalid;
    logic [9:0] offs;
    logic [9:0] trim_s1;
    logic [9:0] trim_s2;
    adcsel_trim_e trim_state;
    logic [2:0] settle_cnt;
    logic loaded;
    adcsel_src_e src;
    logic [2:0] pin;
    logic [7:0] pin_onehot;
    logic cap_discharge;
    logic sensor_drive_en;
    logic sensor_route;
    logic sensor_valid;
    logic sel_reserved;
    logic skip_ground_seen;
  } adcsel_state_s;

endpackage

//--- logic/adcsel_decode.sv
// Purpose: decode a 5-bit channel code into source class and pin
// Assumes: purely combinational, fed from logic on the same clock
// Notes: reserved codes decode to SRC_RSVD with no pin selected
`timescale 1ns/1ps
`include "adcsel_defs.svh"

module adcsel_decode (
  input wire logic [4:0] code,
  output adcsel_pkg::adcsel_src_e src,
  output logic [2:0] pin,
  output logic [7:0] pin_onehot
);

  logic pin_valid;

  always_comb begin
    src = adcsel_pkg::SRC_RSVD;
    pin = code[2:0];
    pin_valid = 1'b0;
    if (code <= `ADCSEL_CODE_P0_LAST) begin
      src = adcsel_pkg::SRC_PORT0; // R1
      pin_valid = 1'b1;
    end else if (code >= `ADCSEL_CODE_P1_FIRST && code <= `ADCSEL_CODE_P1_LAST) begin
      src = adcsel_pkg::SRC_PORT1; // R1
      pin_valid = 1'b1;
    end else if (code >= `ADCSEL_CODE_P2_FIRST && code <= `ADCSEL_CODE_P2_LAST) begin
      src = adcsel_pkg::SRC_PORT2; // R1
      pin_valid = 1'b1;
    end else begin
      case (code)
        `ADCSEL_CODE_TEMP: src = adcsel_pkg::SRC_TEMP; // R2 R5
        `ADCSEL_CODE_VDD: src = adcsel_pkg::SRC_VDD; // R2
        `ADCSEL_CODE_VREG: src = adcsel_pkg::SRC_VREG; // R2
        `ADCSEL_CODE_VDD_ALT: src = adcsel_pkg::SRC_VDD; // R2
        `ADCSEL_CODE_GND: src = adcsel_pkg::SRC_GND; // R2
        default: src = adcsel_pkg::SRC_RSVD; // R12
      endcase
    end
    if (!pin_valid) begin
      pin = 3'h0;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_pin
      assign pin_onehot[g] = pin_valid && (code[2:0] == 3'(g));
    end
  endgenerate

endmodule

//--- testbench/adcsel_asserts.sv
// Purpose: port checks for adcsel_top
// Assumes: one clock, async reset
// Notes: bound at the foot
`timescale 1ns/1ps
module adcsel_chk (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [3:0] sfr_page,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_rvalid,
  input wire logic [4:0] input_channel_field,
  input wire logic cap_discharge,
  input wire logic sensor_drive_en,
  input wire logic sensor_route,
  input wire logic sensor_result_valid,
  input wire logic offset_loaded
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic wr_ch;
  assign wr_ch = sfr_wr && sfr_page == 4'h0 && sfr_addr == 8'hBB;
  sequence s_rd_ch; sfr_rd && !sfr_wr && sfr_page == 4'h0 && sfr_addr == 8'hBB; endsequence
  sequence s_rd_lo; sfr_rd && sfr_page == 4'hF && sfr_addr == 8'h85; endsequence
  AST_RVALID: assert property (1 |=> sfr_rvalid == $past(sfr_rd))
    else $error("rvalid timing");
  AST_WR_CHAN: assert property (wr_ch |=> {3'h0, input_channel_field} == ($past(sfr_wdata) & 8'h1F))
    else $error("channel write lost");
  AST_HOLD: assert property (!wr_ch |=> $stable(input_channel_field))
    else $error("channel changed");
  AST_RD_CHAN: assert property (s_rd_ch |=> sfr_rdata == {3'h0, $past(input_channel_field)})
    else $error("channel read");
  AST_RD_LOW: assert property (s_rd_lo |=> sfr_rvalid && sfr_rdata[5:0] == 6'h00)
    else $error("low offset bits");
  AST_GND: assert property (cap_discharge == (input_channel_field == 5'h1F))
    else $error("discharge");
  AST_SENSOR: assert property (sensor_result_valid == (sensor_route && sensor_drive_en))
    else $error("sensor valid");
  AST_LOADED: assert property (offset_loaded |=> offset_loaded)
    else $error("offset lost");
endmodule
bind adcsel_top adcsel_chk u_chk (.sys_clk, .sys_rst, .sfr_page, .sfr_addr, .sfr_wr, .sfr_rd,
  .sfr_wdata, .sfr_rdata, .sfr_rvalid, .input_channel_field, .cap_discharge,
  .sensor_drive_en, .sensor_route, .sensor_result_valid, .offset_loaded);

//--- testbench/adcsel_analog_model.sv
// Purpose: analog side: factory offset pins and sensor enable
// Assumes: offset fixed from power-up
// Notes: enable follows the bench request
`timescale 1ns/1ps
module adcsel_analog_model #(
  parameter logic [9:0] FACTORY_OFFSET = 10'h000
) (
  input wire logic sensor_on,
  output logic temp_sensor_enable,
  output logic [9:0] temp_offset_value
);
  assign temp_offset_value = FACTORY_OFFSET;
  assign temp_sensor_enable = sensor_on;
endmodule

//--- testbench/tb_adc_input_select_temp_offset.sv
// Purpose: self-checking bench for adcsel_top
// Assumes: 100 MHz clock, reset held 8 cycles
// Notes: random codes and addresses from a fixed seed
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module tb_adc_input_select_temp_offset;
  localparam logic [9:0] OFFS = 10'h2D9;
  logic sys_clk = 0, sys_rst = 1, sfr_wr = 0, sfr_rd = 0, sensor_on = 0;
  logic [3:0] sfr_page = 0, p;
  logic [7:0] sfr_addr = 0, sfr_wdata = 0, sfr_rdata, v, a;
  logic sfr_rvalid, temp_sensor_enable, cap_discharge, sensor_route, sensor_result_valid;
  logic sensor_drive_en, sel_reserved, skip_ground_seen, offset_loaded;
  logic [9:0] temp_offset_value;
  logic [4:0] input_channel_field, chan_m;
  logic [2:0] mux_pin;
  logic [7:0] mux_pin_onehot;
  adcsel_pkg::adcsel_src_e analog_input_mux;
  int error_cnt = 0, n_checks = 0;
  adcsel_analog_model #(.FACTORY_OFFSET(OFFS)) far (.sensor_on, .temp_sensor_enable,
    .temp_offset_value);
  adcsel_top dut (.sys_clk, .sys_rst, .sfr_page, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
    .sfr_rdata, .sfr_rvalid, .temp_offset_value, .temp_sensor_enable, .input_channel_field,
    .analog_input_mux, .mux_pin, .mux_pin_onehot, .cap_discharge, .sensor_drive_en,
    .sensor_route, .sensor_result_valid, .sel_reserved, .skip_ground_seen, .offset_loaded);
  initial forever #5 sys_clk = ~sys_clk;
  function automatic adcsel_pkg::adcsel_src_e exp_src(logic [4:0] c);
    if (c <= 5'h07) return adcsel_pkg::SRC_PORT0;
    if (c >= 5'h0D && c <= 5'h0F) return adcsel_pkg::SRC_PORT1;
    if (c >= 5'h10 && c <= 5'h16) return adcsel_pkg::SRC_PORT2;
    if (c == 5'h1B) return adcsel_pkg::SRC_TEMP;
    if (c == 5'h1C || c == 5'h1E) return adcsel_pkg::SRC_VDD;
    if (c == 5'h1D) return adcsel_pkg::SRC_VREG;
    if (c == 5'h1F) return adcsel_pkg::SRC_GND;
    return adcsel_pkg::SRC_RSVD;
  endfunction
  function automatic logic [7:0] exp_rd(logic [3:0] pg, logic [7:0] ad);
    if (pg == 4'h0 && ad == 8'hBB) return {3'h0, chan_m};
    if (pg == 4'hF && ad == 8'h86) return OFFS[9:2];
    if (pg == 4'hF && ad == 8'h85) return {OFFS[1:0], 6'h00};
    return 8'h00;
  endfunction
  task automatic wr(input logic [3:0] pg, input logic [7:0] ad, input logic [7:0] d);
    @(posedge sys_clk);
    sfr_wr <= 1'b1;
    sfr_page <= pg;
    sfr_addr <= ad;
    sfr_wdata <= d;
    @(posedge sys_clk);
    sfr_wr <= 1'b0;
    if (pg == 4'h0 && ad == 8'hBB) chan_m = d[4:0];
    #1;
  endtask
  task automatic rd(input logic [3:0] pg, input logic [7:0] ad);
    @(posedge sys_clk);
    sfr_rd <= 1'b1;
    sfr_page <= pg;
    sfr_addr <= ad;
    @(posedge sys_clk);
    sfr_rd <= 1'b0;
    #1;
    `CHK("read", {1'b1, exp_rd(pg, ad)}, {sfr_rvalid, sfr_rdata})
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    end_sim();
  end
  initial begin
    void'($urandom(32'hF85E28CB));
    chan_m = 5'h1F;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(4'h0, 8'hBB);
    `CHK("gnd", adcsel_pkg::SRC_GND, analog_input_mux)
    repeat (6) @(posedge sys_clk);
    `CHK("loaded", 1'b1, offset_loaded)
    rd(4'hF, 8'h86);
    wr(4'hF, 8'h86, 8'($urandom));
    wr(4'hF, 8'h85, 8'hFF);
    rd(4'hF, 8'h86);
    rd(4'hF, 8'h85);
    $display("test offset done");
    for (int c = 0; c < 32; c++) begin
      v = {3'($urandom), 5'(c)};
      wr(4'h0, 8'hBB, v);
      `CHK("src", exp_src(v[4:0]), analog_input_mux)
      `CHK("pin", exp_src(v[4:0]) <= adcsel_pkg::SRC_PORT2 ? v[2:0] : 3'h0, mux_pin)
      `CHK("onehot", exp_src(v[4:0]) <= adcsel_pkg::SRC_PORT2 ? 8'h01 << v[2:0] : 8'h00, mux_pin_onehot)
      `CHK("discharge", v[4:0] == 5'h1F, cap_discharge)
      `CHK("rsvd", exp_src(v[4:0]) == adcsel_pkg::SRC_RSVD, sel_reserved)
      rd(4'h0, 8'hBB);
    end
    $display("test codes done");
    @(posedge sys_clk);
    sensor_on <= 1'b1;
    wr(4'h0, 8'hBB, 8'h1F);
    wr(4'h0, 8'hBB, 8'h1B);
    `CHK("route", 1'b1, sensor_route)
    `CHK("valid", 1'b1, sensor_result_valid)
    `CHK("skip", 1'b0, skip_ground_seen)
    rd(4'hF, 8'h86);
    @(posedge sys_clk);
    sensor_on <= 1'b0;
    @(posedge sys_clk);
    #1;
    `CHK("hiz", 2'b00, {sensor_drive_en, sensor_result_valid})
    wr(4'h0, 8'hBB, 8'h03);
    wr(4'h0, 8'hBB, 8'h1B);
    `CHK("skip", 1'b1, skip_ground_seen)
    $display("test sensor done");
    repeat (60) begin
      p = $urandom_range(1) ? 4'hF : 4'h0;
      a = $urandom_range(3) == 0 ? 8'($urandom) : (p == 4'h0 ? 8'hBB : 8'h85 + 8'($urandom_range(1)));
      if ($urandom_range(1)) wr(p, a, 8'($urandom));
      else rd(p, a);
    end
    $display("test random done");
    end_sim();
  end
endmodule
